// ==== mlr_pkg.sv ====
`default_nettype none
package mlr_pkg;
    // register byte offsets
    localparam logic [7:0] MLR_OFS_CMD = 8'h00;
    localparam logic [7:0] MLR_OFS_OPERAND = 8'h04;
    localparam logic [7:0] MLR_OFS_ACC = 8'h08;
    localparam logic [7:0] MLR_OFS_FLAGS = 8'h0C;
    localparam logic [7:0] MLR_OFS_RESULT = 8'h10;

    // field positions
    localparam int MLR_POS_IMM = 8;
    localparam int MLR_POS_MEM_WRITTEN = 8;
    localparam int MLR_POS_SKIP = 9;
    localparam int MLR_POS_CYCLES = 10;
    localparam int MLR_POS_BUSY = 12;

    // reset values
    localparam logic [7:0] MLR_RST_BYTE = 8'h00;
    localparam logic [4:0] MLR_RST_OP = 5'h00;

    // cycle counts of an executed instruction
    localparam logic [1:0] MLR_CYC_NORMAL = 2'h1;
    localparam logic [1:0] MLR_CYC_SKIP = 2'h2;

    // operation codes written to the command register
    localparam logic [4:0] MLR_OP_NOP = 5'h00;
    localparam logic [4:0] MLR_OP_LOAD_IMMEDIATE_ACC = 5'h01;
    localparam logic [4:0] MLR_OP_MOVE_ACC_MEM = 5'h02;
    localparam logic [4:0] MLR_OP_ROTATE_LEFT_MEM = 5'h03;
    localparam logic [4:0] MLR_OP_ROTATE_LEFT_TO_ACC = 5'h04;
    localparam logic [4:0] MLR_OP_ROTATE_LEFT_CARRY_MEM = 5'h05;
    localparam logic [4:0] MLR_OP_ROTATE_LEFT_CARRY_TO_ACC = 5'h06;
    localparam logic [4:0] MLR_OP_ROTATE_RIGHT_MEM = 5'h07;
    localparam logic [4:0] MLR_OP_ROTATE_RIGHT_TO_ACC = 5'h08;
    localparam logic [4:0] MLR_OP_ROTATE_RIGHT_CARRY_MEM = 5'h09;
    localparam logic [4:0] MLR_OP_ROTATE_RIGHT_CARRY_TO_ACC = 5'h0A;
    localparam logic [4:0] MLR_OP_OR_ACC_MEM = 5'h0B;
    localparam logic [4:0] MLR_OP_OR_ACC_IMM = 5'h0C;
    localparam logic [4:0] MLR_OP_OR_TO_MEM = 5'h0D;
    localparam logic [4:0] MLR_OP_SUBTRACT_WITH_BORROW = 5'h0E;
    localparam logic [4:0] MLR_OP_SUBTRACT_WITH_BORROW_MEM = 5'h0F;
    localparam logic [4:0] MLR_OP_DECREMENT_SKIP_ZERO = 5'h10;
    localparam logic [4:0] MLR_OP_DECREMENT_SKIP_ZERO_TO_ACC = 5'h11;

    localparam logic [1:0] MLR_HTRANS_NONSEQ = 2'h2;

    typedef struct packed {
        logic overflow_flag;
        logic zero;
        logic aux_carry_flag;
        logic carry;
    } mlr_flags_type;

    typedef struct packed {
        logic [7:0] acc;
        logic [7:0] mem;
        mlr_flags_type flags;
        logic mem_written;
        logic skip;
    } mlr_exec_type;

    typedef enum logic [1:0] {
        MLR_IDLE,
        MLR_EXEC,
        MLR_DUMMY
    } mlr_state_type;
endpackage
`default_nettype wire

// ==== mlr_exec.sv ====
// Implementation choices: register access over AHB-Lite and the register offsets.
`default_nettype none
// Behaviour
// - immediate load puts the instruction constant into the accumulator, flags untouched
// - memory rotate left through carry: bit 7 to carry, old carry to bit 0
// - rotate left through carry to accumulator changes only the carry flag
// - rotate left through carry to accumulator leaves the memory byte alone
// - memory rotate right: bit 0 wraps into bit 7, no flag changes
// - rotate right to accumulator: rotated byte into accumulator, no flag changes
// - rotate right to accumulator keeps the memory byte unchanged
// - memory rotate right through carry: bit 0 to carry, old carry to bit 7
// - rotate right through carry to accumulator, carry from bit 0, memory unchanged
// - a met skip condition adds a dummy cycle: two cycles, else one
module mlr_exec
    import mlr_pkg::*;
(
    input wire logic hclk, // system clock
    input wire logic hresetn, // asynchronous reset
    input wire logic hsel, // slave select
    input wire logic [31:0] haddr, // byte address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write strobe
    input wire logic [2:0] hsize, // transfer size
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // bus ready in
    output logic [31:0] hrdata, // read data
    output logic hreadyout, // slave ready
    output logic hresp // response, always okay
);
    mlr_state_type state_q, state_d;
    logic [4:0] op_q, op_d;
    logic [7:0] mem_in_q, mem_in_d;
    logic [7:0] imm_q, imm_d;
    logic [7:0] acc_q, acc_d;
    mlr_flags_type flags_q, flags_d;
    logic [7:0] mem_res_q, mem_res_d;
    logic mem_wr_q, mem_wr_d;
    logic skip_q, skip_d;
    logic [1:0] cycles_q, cycles_d;
    logic [7:0] addr_q, addr_d;
    logic wr_q, wr_d;
    logic rd_q, rd_d;
    logic [31:0] hrdata_d;
    logic ready_d;
    mlr_exec_type ex;
    logic accept;
    logic wr_done;
    logic [7:0] rd_addr;
    logic [8:0] diff;
    logic [4:0] diff_lo;
    logic [7:0] m;
    logic [7:0] dec;

    assign accept = hsel && hready && (htrans == MLR_HTRANS_NONSEQ);
    assign wr_done = wr_q && hreadyout;
    assign rd_addr = accept ? haddr[7:0] : addr_q;
    assign m = mem_in_q;
    assign dec = m - 8'h01;

    // datapath of the executed operation
    always_comb begin
        ex.acc = acc_q;
        ex.mem = m;
        ex.flags = flags_q;
        ex.mem_written = 1'b0;
        ex.skip = 1'b0;
        diff = {1'b0, acc_q} + {1'b0, ~m} + {8'h00, flags_q.carry};
        diff_lo = {1'b0, acc_q[3:0]} + {1'b0, ~m[3:0]} + {4'h0, flags_q.carry};
        unique case (op_q)
            MLR_OP_LOAD_IMMEDIATE_ACC: begin
                ex.acc = imm_q;
            end
            MLR_OP_MOVE_ACC_MEM: begin
                ex.mem = acc_q;
                ex.mem_written = 1'b1;
            end
            MLR_OP_ROTATE_LEFT_MEM: begin
                ex.mem = {m[6:0], m[7]};
                ex.mem_written = 1'b1;
            end
            MLR_OP_ROTATE_LEFT_TO_ACC: begin
                ex.acc = {m[6:0], m[7]};
            end
            MLR_OP_ROTATE_LEFT_CARRY_MEM: begin
                ex.mem = {m[6:0], flags_q.carry};
                ex.flags.carry = m[7];
                ex.mem_written = 1'b1;
            end
            MLR_OP_ROTATE_LEFT_CARRY_TO_ACC: begin
                ex.acc = {m[6:0], flags_q.carry};
                ex.flags.carry = m[7];
            end
            MLR_OP_ROTATE_RIGHT_MEM: begin
                ex.mem = {m[0], m[7:1]};
                ex.mem_written = 1'b1;
            end
            MLR_OP_ROTATE_RIGHT_TO_ACC: begin
                ex.acc = {m[0], m[7:1]};
            end
            MLR_OP_ROTATE_RIGHT_CARRY_MEM: begin
                ex.mem = {flags_q.carry, m[7:1]};
                ex.flags.carry = m[0];
                ex.mem_written = 1'b1;
            end
            MLR_OP_ROTATE_RIGHT_CARRY_TO_ACC: begin
                ex.acc = {flags_q.carry, m[7:1]};
                ex.flags.carry = m[0];
            end
            MLR_OP_OR_ACC_MEM: begin
                ex.acc = acc_q | m;
                ex.flags.zero = ((acc_q | m) == 8'h00);
            end
            MLR_OP_OR_ACC_IMM: begin
                ex.acc = acc_q | imm_q;
                ex.flags.zero = ((acc_q | imm_q) == 8'h00);
            end
            MLR_OP_OR_TO_MEM: begin
                ex.mem = acc_q | m;
                ex.mem_written = 1'b1;
                ex.flags.zero = ((acc_q | m) == 8'h00);
            end
            MLR_OP_SUBTRACT_WITH_BORROW, MLR_OP_SUBTRACT_WITH_BORROW_MEM: begin
                if (op_q == MLR_OP_SUBTRACT_WITH_BORROW) begin
                    ex.acc = diff[7:0];
                end else begin
                    ex.mem = diff[7:0];
                    ex.mem_written = 1'b1;
                end
                ex.flags.carry = diff[8];
                ex.flags.aux_carry_flag = diff_lo[4];
                ex.flags.zero = (diff[7:0] == 8'h00);
                ex.flags.overflow_flag = (acc_q[7] != m[7]) && (diff[7] != acc_q[7]);
            end
            MLR_OP_DECREMENT_SKIP_ZERO: begin
                ex.mem = dec;
                ex.mem_written = 1'b1;
                ex.skip = (dec == 8'h00);
            end
            MLR_OP_DECREMENT_SKIP_ZERO_TO_ACC: begin
                ex.acc = dec;
                ex.skip = (dec == 8'h00);
            end
            default: begin
                ex.acc = acc_q;
            end
        endcase
    end

    // sequencing, register writes and execution results
    always_comb begin
        state_d = state_q;
        op_d = op_q;
        mem_in_d = mem_in_q;
        imm_d = imm_q;
        acc_d = acc_q;
        flags_d = flags_q;
        mem_res_d = mem_res_q;
        mem_wr_d = mem_wr_q;
        skip_d = skip_q;
        cycles_d = cycles_q;
        unique case (state_q)
            MLR_IDLE: begin
                if (wr_done) begin
                    unique case (addr_q)
                        MLR_OFS_CMD: begin
                            op_d = hwdata[4:0];
                            state_d = MLR_EXEC;
                        end
                        MLR_OFS_OPERAND: begin
                            mem_in_d = hwdata[7:0];
                            imm_d = hwdata[MLR_POS_IMM +: 8];
                        end
                        MLR_OFS_ACC: acc_d = hwdata[7:0];
                        MLR_OFS_FLAGS: flags_d = hwdata[3:0];
                        default: ;
                    endcase
                end
            end
            MLR_EXEC: begin
                acc_d = ex.acc;
                flags_d = ex.flags;
                mem_res_d = ex.mem;
                mem_wr_d = ex.mem_written;
                skip_d = ex.skip;
                cycles_d = ex.skip ? MLR_CYC_SKIP : MLR_CYC_NORMAL;
                state_d = ex.skip ? MLR_DUMMY : MLR_IDLE;
            end
            MLR_DUMMY: begin
                state_d = MLR_IDLE;
            end
        endcase
    end

    // bus phase tracking and read data
    always_comb begin
        addr_d = addr_q;
        wr_d = wr_q;
        rd_d = rd_q;
        if (hreadyout) begin
            addr_d = haddr[7:0];
            wr_d = accept && hwrite;
            rd_d = accept && !hwrite;
        end
        ready_d = (state_d == MLR_IDLE);
        hrdata_d = 32'h0000_0000;
        if (accept || rd_q) begin
            unique case (rd_addr)
                MLR_OFS_CMD: hrdata_d[4:0] = op_d;
                MLR_OFS_OPERAND: hrdata_d[15:0] = {imm_d, mem_in_d};
                MLR_OFS_ACC: hrdata_d[7:0] = acc_d;
                MLR_OFS_FLAGS: hrdata_d[3:0] = flags_d;
                MLR_OFS_RESULT: begin
                    hrdata_d[7:0] = mem_res_d;
                    hrdata_d[MLR_POS_MEM_WRITTEN] = mem_wr_d;
                    hrdata_d[MLR_POS_SKIP] = skip_d;
                    hrdata_d[MLR_POS_CYCLES +: 2] = cycles_d;
                    hrdata_d[MLR_POS_BUSY] = (state_d != MLR_IDLE);
                end
                default: hrdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= MLR_IDLE;
            op_q <= MLR_RST_OP;
            mem_in_q <= MLR_RST_BYTE;
            imm_q <= MLR_RST_BYTE;
            acc_q <= MLR_RST_BYTE;
            flags_q <= '0;
            mem_res_q <= MLR_RST_BYTE;
            mem_wr_q <= 1'b0;
            skip_q <= 1'b0;
            cycles_q <= 2'h0;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            state_q <= state_d;
            op_q <= op_d;
            mem_in_q <= mem_in_d;
            imm_q <= imm_d;
            acc_q <= acc_d;
            flags_q <= flags_d;
            mem_res_q <= mem_res_d;
            mem_wr_q <= mem_wr_d;
            skip_q <= skip_d;
            cycles_q <= cycles_d;
            addr_q <= addr_d;
            wr_q <= wr_d;
            rd_q <= rd_d;
            hrdata <= hrdata_d;
            hreadyout <= ready_d;
            hresp <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== mlr_exec_checker.sv ====
`default_nettype none
module mlr_exec_checker
    import mlr_pkg::*;
(
    input wire logic hclk, // clock
    input wire logic hresetn, // reset
    input wire logic hsel, // select
    input wire logic [31:0] haddr, // address
    input wire logic [1:0] htrans, // transfer type
    input wire logic hwrite, // write
    input wire logic [31:0] hwdata, // write data
    input wire logic hready, // ready in
    input wire logic [31:0] hrdata, // read data
    input wire logic hreadyout, // ready out
    input wire logic hresp // response
);
    logic dp_q, dw_q;
    logic [7:0] da_q, opnd_q, mem_q;
    logic [4:0] op_q;
    logic [1:0] cnt_q;
    wire logic done = dp_q && hreadyout;
    wire logic cmd = done && dw_q && da_q == MLR_OFS_CMD;
    wire logic rres = done && !dw_q && da_q == MLR_OFS_RESULT;
    wire logic runm = done && !dw_q && (da_q > MLR_OFS_RESULT || da_q[1:0] != 2'h0);

    // counts stall cycles since the last command write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_q <= 1'b0;
            cnt_q <= 2'h0;
            op_q <= MLR_OP_NOP;
        end else begin
            if (hready) begin
                dp_q <= hsel && htrans == MLR_HTRANS_NONSEQ;
            end
            if (cmd) begin
                cnt_q <= 2'h0;
                op_q <= hwdata[4:0];
            end else if (!hreadyout) begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge hclk) begin
        if (hready) begin
            da_q <= haddr[7:0];
            dw_q <= hwrite;
        end
        if (done && dw_q && da_q == MLR_OFS_OPERAND) begin
            opnd_q <= hwdata[7:0];
        end
        if (cmd) begin
            mem_q <= opnd_q;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    exec_start_a: assert property (cmd |=> !hreadyout)
        else $error("command did not stall");
    exec_bounded_a: assert property ($fell(hreadyout) |-> ##[1:2] hreadyout)
        else $error("stall too long");
    stall_cause_a: assert property ($fell(hreadyout) |-> $past(cmd))
        else $error("stall without command");
    cycles_match_a: assert property (
        rres |-> hrdata[12:9] == {1'b0, cnt_q, cnt_q == 2'h2})
        else $error("cycle count mismatch");
    acc_dest_kept_a: assert property (
        rres && op_q inside {5'h04, 5'h06, 5'h08, 5'h0A} |-> hrdata[8:0] == {1'b0, mem_q})
        else $error("memory byte changed");
    rotr_value_a: assert property (rres && op_q == 5'h07
        |-> hrdata[8:0] == {1'b1, mem_q[0], mem_q[7:1]}) else $error("rotate right wrong");
    rotl_carry_a: assert property (rres && op_q == 5'h05
        |-> hrdata[8:1] == {1'b1, mem_q[6:0]}) else $error("rotate left carry wrong");
    rotr_carry_a: assert property (rres && op_q == 5'h09
        |-> hrdata[8] && hrdata[6:0] == mem_q[7:1]) else $error("rotate right carry wrong");
    unmapped_zero_a: assert property (runm |-> hrdata == 32'h0)
        else $error("unmapped read not zero");

    cover property (cmd);
    cover property (!hreadyout [*2]);
    cover property (rres && op_q == 5'h07);
    cover property (rres && hrdata[9]);
endmodule
`default_nettype wire

// ==== mlr_exec_tb_top.sv ====
`default_nettype none
module mlr_exec_tb_top
    import mlr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int fail_count, n_checks;

    mlr_exec i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one single transfer; entered right after a rising edge
    task automatic xfer(input logic w, logic [7:0] a, logic [31:0] d);
        hsel <= 1'b1;
        htrans <= MLR_HTRANS_NONSEQ;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    // ms holds {skip taken, memory written}
    task automatic exec(input logic [4:0] op, logic [15:0] opnd, logic [7:0] acc, logic [3:0] fl,
        logic [7:0] ea, logic [3:0] ef, logic [7:0] em, logic [1:0] ms);
        xfer(1'b1, MLR_OFS_OPERAND, {16'h0, opnd});
        xfer(1'b1, MLR_OFS_ACC, {24'h0, acc});
        xfer(1'b1, MLR_OFS_FLAGS, {28'h0, fl});
        xfer(1'b1, MLR_OFS_CMD, {27'h0, op});
        xfer(1'b0, MLR_OFS_ACC, 32'h0);
        chk(rd, {24'h0, ea});
        xfer(1'b0, MLR_OFS_FLAGS, 32'h0);
        chk(rd, {28'h0, ef});
        xfer(1'b0, MLR_OFS_RESULT, 32'h0);
        chk(rd, {19'h0, 1'b0, ms[1] ? MLR_CYC_SKIP : MLR_CYC_NORMAL, ms, em});
        xfer(1'b0, MLR_OFS_OPERAND, 32'h0);
        chk(rd, {16'h0, opnd});
        xfer(1'b0, MLR_OFS_CMD, 32'h0);
        chk(rd, {27'h0, op});
        $display("test op %h done", op);
    endtask

    initial begin
        #20000;
        fail_count++;
        close_out();
    end

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 16; a += 4) begin
            xfer(1'b0, 8'(a), 32'h0);
            chk(rd, 32'h0);
        end
        xfer(1'b1, MLR_OFS_RESULT, 32'h0000_FFFF);
        xfer(1'b1, 8'h14, 32'h0000_0055);
        xfer(1'b0, MLR_OFS_RESULT, 32'h0);
        chk(rd, 32'h0);
        xfer(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        $display("test registers done");
        exec(5'h01, 16'h3CA5, 8'h12, 4'hF, 8'h3C, 4'hF, 8'hA5, 2'h0);
        exec(5'h02, 16'h0000, 8'h77, 4'h5, 8'h77, 4'h5, 8'h77, 2'h1);
        exec(5'h05, 16'h00A5, 8'h00, 4'hE, 8'h00, 4'hF, 8'h4A, 2'h1);
        exec(5'h06, 16'h0025, 8'h00, 4'h1, 8'h4B, 4'h0, 8'h25, 2'h0);
        exec(5'h07, 16'h00A5, 8'h11, 4'hA, 8'h11, 4'hA, 8'hD2, 2'h1);
        exec(5'h08, 16'h004C, 8'h00, 4'h5, 8'h26, 4'h5, 8'h4C, 2'h0);
        exec(5'h09, 16'h0081, 8'h00, 4'h6, 8'h00, 4'h7, 8'h40, 2'h1);
        exec(5'h0A, 16'h0002, 8'h00, 4'hF, 8'h81, 4'hE, 8'h02, 2'h0);
        exec(5'h0C, 16'h00FF, 8'h00, 4'hB, 8'h00, 4'hF, 8'hFF, 2'h0);
        exec(5'h0B, 16'h000A, 8'h50, 4'hF, 8'h5A, 4'hB, 8'h0A, 2'h0);
        exec(5'h0D, 16'h0018, 8'h81, 4'h4, 8'h81, 4'h0, 8'h99, 2'h1);
        exec(5'h0E, 16'h0001, 8'h10, 4'hF, 8'h0F, 4'h1, 8'h01, 2'h0);
        exec(5'h0E, 16'h0005, 8'h05, 4'h9, 8'h00, 4'h7, 8'h05, 2'h0);
        exec(5'h0F, 16'h0001, 8'h80, 4'h0, 8'h80, 4'h9, 8'h7E, 2'h1);
        exec(5'h10, 16'h0001, 8'h33, 4'h5, 8'h33, 4'h5, 8'h00, 2'h3);
        exec(5'h10, 16'h0000, 8'h33, 4'h5, 8'h33, 4'h5, 8'hFF, 2'h1);
        exec(5'h11, 16'h0001, 8'h33, 4'hA, 8'h00, 4'hA, 8'h01, 2'h2);
        exec(5'h00, 16'h1234, 8'h56, 4'h9, 8'h56, 4'h9, 8'h34, 2'h0);
        exec(5'h03, 16'h0081, 8'h00, 4'h0, 8'h00, 4'h0, 8'h03, 2'h1);
        exec(5'h04, 16'h00C1, 8'h00, 4'h5, 8'h83, 4'h5, 8'hC1, 2'h0);
        exec(5'h1F, 16'h00C3, 8'hA0, 4'h6, 8'hA0, 4'h6, 8'hC3, 2'h0);
        close_out();
    end
endmodule

bind mlr_exec mlr_exec_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire
